// [decoder_pkg.sv]
// constants, field layout and register map of the instruction field decoder
package decoder_pkg;
    // instruction word layout
    localparam int WORD_W     = 14;
    localparam int OPC_HI     = 13;
    localparam int OPC_LO     = 8;
    localparam int DEST_POS   = 7;
    localparam int BIT_HI     = 9;
    localparam int BIT_LO     = 7;
    localparam int REG_W      = 7;
    localparam int LIT_W      = 11;
    localparam int LIT8_W     = 8;
    // oscillator periods per instruction cycle
    localparam int PERIODS    = 4;
    // register byte offsets
    localparam logic [7:0] CTRL_OFF   = 8'h00;
    localparam logic [7:0] WORD_OFF   = 8'h04;
    localparam logic [7:0] FIELDS_OFF = 8'h08;
    localparam logic [7:0] CYCLES_OFF = 8'h0c;
    // control fields and reset
    localparam int CTRL_RUN_BIT = 0;
    localparam int CTRL_CLR_BIT = 1;
    localparam logic CTRL_RUN_RST = 1'b1;
    // fixed words that leave through the return path
    localparam logic [13:0] RETURN_WORD = 14'h0008;
    localparam logic [13:0] RETFIE_WORD = 14'h0009;
    // axi responses
    localparam logic [1:0] RESP_OKAY   = 2'b00;
    localparam logic [1:0] RESP_SLVERR = 2'b10;

    typedef enum logic [1:0] {
        GRP_BYTE = 2'b00,
        GRP_BIT  = 2'b01,
        GRP_LIT  = 2'b10
    } group_e;
endpackage

// [fetch_model.sv]
// fetch and datapath stand-in: serves program words and feedback flags
`timescale 1ns/10ps
module fetch_model (
    // clock and reset
    input  wire logic        aclk,
    input  wire logic        aresetn,
    // decoder outputs watched
    input  wire logic        cycle_start_o,
    input  wire logic        nop_cycle_o,
    // fetch and feedback
    output logic [13:0]      instr_in,
    output logic             test_true,
    output logic             pc_written
);
    logic [13:0] prog [32];
    logic        tt   [32];
    logic        pw   [32];
    logic [4:0]  idx;

    initial begin
        instr_in   = '0;
        test_true  = 1'b0;
        pc_written = 1'b0;
        for (int i = 0; i < 32; i++) begin
            prog[i] = '0;
            tt[i]   = 1'b0;
            pw[i]   = 1'b0;
        end
    end

    // flags stay up through phase 3 of the executing word; a nop cycle keeps the next word presented
    always @(posedge aclk) begin
        if (!aresetn) begin
            idx        <= '0;
            instr_in   <= prog[0];
            test_true  <= 1'b0;
            pc_written <= 1'b0;
        end else if (cycle_start_o) begin
            if (nop_cycle_o) begin
                test_true  <= 1'b0;
                pc_written <= 1'b0;
            end else begin
                test_true  <= tt[idx];
                pc_written <= pw[idx];
                idx        <= idx + 5'd1;
                instr_in   <= prog[idx + 5'd1];
            end
        end
    end
endmodule

// [instr_decoder.sv]
// instruction field decoder with axi4-lite status and control registers
// Functional notes
// - each instruction arrives as one 14-bit word split into an opcode part and operand parts.
// - every instruction falls in exactly one group: byte register, bit register, or literal and control.
// - in the byte group a destination bit of 0 writes the accumulator and 1 writes the addressed register.
// - the register index operand is seven bits wide, covering 0x00 to 0x7f.
// - in the bit group a three-bit position picks the bit of the addressed 8-bit register.
// - in the literal group the constant is eleven bits for jumps and calls, otherwise eight.
// - an instruction takes one cycle, or two when a test is true or the program counter changes, the second a no-op.
// - one instruction cycle is four consecutive core clock periods.
// - don't-care bit positions are ignored whatever their value; generators should fill them with 0.
// - the top two opcode bits pick the group: 00 byte, 01 bit, 10 or 11 literal and control.
`timescale 1ns/10ps
module instr_decoder #(
    parameter int ADDR_W = 8
) (
    // clock and reset
    input  wire logic              aclk,
    input  wire logic              aresetn,
    // axi4-lite slave
    input  wire logic [ADDR_W-1:0] awaddr,
    input  wire logic              awvalid,
    output logic                   awready,
    input  wire logic [31:0]       wdata,
    input  wire logic [3:0]        wstrb,
    input  wire logic              wvalid,
    output logic                   wready,
    output logic [1:0]             bresp,
    output logic                   bvalid,
    input  wire logic              bready,
    input  wire logic [ADDR_W-1:0] araddr,
    input  wire logic              arvalid,
    output logic                   arready,
    output logic [31:0]            rdata,
    output logic [1:0]             rresp,
    output logic                   rvalid,
    input  wire logic              rready,
    // fetch side
    input  wire logic [13:0]       instr_in,
    // datapath feedback, sampled in the last clock of a cycle
    input  wire logic              test_true,
    input  wire logic              pc_written,
    // decoded fields to datapath
    output logic                   cycle_start_o,
    output logic [1:0]             group_o,
    output logic [5:0]             opcode_o,
    output logic [6:0]             reg_idx_o,
    output logic                   wr_acc_o,
    output logic                   wr_file_o,
    output logic [2:0]             bit_pos_o,
    output logic [10:0]            literal_o,
    output logic                   lit_wide_o,
    output logic                   nop_cycle_o
);
    phase_if ph ();

    quarter_div #(.PERIODS(decoder_pkg::PERIODS)) u_div (
        .aclk    (aclk),
        .aresetn (aresetn),
        .ph      (ph)
    );

    logic        run_r;
    logic [13:0] word_r;
    logic [1:0]  group_r;
    logic [5:0]  opcode_r;
    logic [6:0]  reg_idx_r;
    logic        wr_acc_r;
    logic        wr_file_r;
    logic [2:0]  bit_pos_r;
    logic [10:0] literal_r;
    logic        lit_wide_r;
    logic        flush_r;
    logic        flush_pend_r;
    logic        pc_chg_r;
    logic        skip_r;
    logic        start_r;
    logic [31:0] cycles_r;

    assign ph.run = run_r;

    // combinational decode of the incoming word
    logic [1:0]  grp_nxt;
    logic        pc_chg_nxt;
    logic        skip_nxt;
    logic [10:0] lit_nxt;
    always_comb begin
        // only the two top bits choose the group
        case (instr_in[13:12])
            2'b00:   grp_nxt = decoder_pkg::GRP_BYTE;
            2'b01:   grp_nxt = decoder_pkg::GRP_BIT;
            default: grp_nxt = decoder_pkg::GRP_LIT;
        endcase
        // jumps, calls, literal return and the two fixed returns move the pc
        pc_chg_nxt = (instr_in[13:12] == 2'b10)
                   || (instr_in[13:10] == 4'b1101)
                   || (instr_in == decoder_pkg::RETURN_WORD)
                   || (instr_in == decoder_pkg::RETFIE_WORD);
        // decrement or increment with skip (1x11), and both bit tests; plain decrement 0011 must not skip
        skip_nxt = ((instr_in[13:12] == 2'b00) && instr_in[11] && (instr_in[9:8] == 2'b11))
                 || (instr_in[13:11] == 3'b011);
        if (instr_in[13:12] == 2'b10) begin
            lit_nxt = instr_in[10:0];
        end else begin
            lit_nxt = {3'h0, instr_in[7:0]};
        end
    end

    // fields latched once per cycle; a flush cycle presents an empty byte op
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            word_r     <= 14'h0000;
            group_r    <= decoder_pkg::GRP_BYTE;
            opcode_r   <= 6'h00;
            reg_idx_r  <= 7'h00;
            wr_acc_r   <= 1'b0;
            wr_file_r  <= 1'b0;
            bit_pos_r  <= 3'h0;
            literal_r  <= 11'h000;
            lit_wide_r <= 1'b0;
            flush_r    <= 1'b0;
            pc_chg_r   <= 1'b0;
            skip_r     <= 1'b0;
        end else if (ph.cycle_start) begin
            flush_r <= flush_pend_r;
            if (flush_pend_r) begin
                word_r     <= 14'h0000;
                group_r    <= decoder_pkg::GRP_BYTE;
                opcode_r   <= 6'h00;
                reg_idx_r  <= 7'h00;
                wr_acc_r   <= 1'b0;
                wr_file_r  <= 1'b0;
                bit_pos_r  <= 3'h0;
                literal_r  <= 11'h000;
                lit_wide_r <= 1'b0;
                pc_chg_r   <= 1'b0;
                skip_r     <= 1'b0;
            end else begin
                word_r     <= instr_in;
                group_r    <= grp_nxt;
                opcode_r   <= instr_in[decoder_pkg::OPC_HI:decoder_pkg::OPC_LO];
                reg_idx_r  <= instr_in[decoder_pkg::REG_W-1:0];
                wr_acc_r   <= (grp_nxt == decoder_pkg::GRP_BYTE) && !instr_in[decoder_pkg::DEST_POS];
                wr_file_r  <= (grp_nxt == decoder_pkg::GRP_BYTE) && instr_in[decoder_pkg::DEST_POS];
                bit_pos_r  <= instr_in[decoder_pkg::BIT_HI:decoder_pkg::BIT_LO];
                literal_r  <= lit_nxt;
                lit_wide_r <= (instr_in[13:12] == 2'b10);
                pc_chg_r   <= pc_chg_nxt;
                skip_r     <= skip_nxt;
            end
        end
    end

    // second-cycle decision taken in the last clock of the cycle
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            flush_pend_r <= 1'b0;
        end else if (ph.cycle_end) begin
            flush_pend_r <= !flush_r && (pc_chg_r || (skip_r && test_true) || pc_written);
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            start_r <= 1'b0;
        end else begin
            start_r <= ph.cycle_start;
        end
    end

    // axi4-lite write channel
    logic              aw_hold_r;
    logic              w_hold_r;
    logic [ADDR_W-1:0] awaddr_r;
    logic [31:0]       wdata_r;
    logic [3:0]        wstrb_r;
    logic              awready_r;
    logic              wready_r;
    logic              bvalid_r;
    logic [1:0]        bresp_r;
    logic              do_write;
    logic              clr_cnt;
    assign do_write = aw_hold_r && w_hold_r && !bvalid_r;
    assign clr_cnt  = do_write && (awaddr_r == ADDR_W'(decoder_pkg::CTRL_OFF))
                    && wstrb_r[0] && wdata_r[decoder_pkg::CTRL_CLR_BIT];

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_hold_r <= 1'b0;
            w_hold_r  <= 1'b0;
            awaddr_r  <= '0;
            wdata_r   <= 32'h0000_0000;
            wstrb_r   <= 4'h0;
            awready_r <= 1'b1;
            wready_r  <= 1'b1;
            bvalid_r  <= 1'b0;
            bresp_r   <= decoder_pkg::RESP_OKAY;
        end else begin
            if (awvalid && awready_r) begin
                aw_hold_r <= 1'b1;
                awaddr_r  <= awaddr;
                awready_r <= 1'b0;
            end
            if (wvalid && wready_r) begin
                w_hold_r <= 1'b1;
                wdata_r  <= wdata;
                wstrb_r  <= wstrb;
                wready_r <= 1'b0;
            end
            if (do_write) begin
                aw_hold_r <= 1'b0;
                w_hold_r  <= 1'b0;
                bvalid_r  <= 1'b1;
                bresp_r   <= (awaddr_r == ADDR_W'(decoder_pkg::CTRL_OFF)) ? decoder_pkg::RESP_OKAY
                                                                          : decoder_pkg::RESP_SLVERR;
            end
            if (bvalid_r && bready) begin
                bvalid_r  <= 1'b0;
                awready_r <= 1'b1;
                wready_r  <= 1'b1;
            end
        end
    end

    // run bit gates both cycle starts and cycle ends; the phase counter keeps turning
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            run_r <= decoder_pkg::CTRL_RUN_RST;
        end else if (do_write && (awaddr_r == ADDR_W'(decoder_pkg::CTRL_OFF)) && wstrb_r[0]) begin
            run_r <= wdata_r[decoder_pkg::CTRL_RUN_BIT];
        end
    end

    // clear wins over count; a count lost on clear is meaningless anyway
    always_ff @(posedge aclk) begin
        if (!aresetn || clr_cnt) begin
            cycles_r <= 32'h0000_0000;
        end else if (ph.cycle_start) begin
            cycles_r <= cycles_r + 32'h0000_0001;
        end
    end

    // axi4-lite read channel
    logic        arready_r;
    logic        rvalid_r;
    logic [31:0] rdata_r;
    logic [1:0]  rresp_r;
    logic [31:0] rd_mux;
    logic        rd_ok;
    always_comb begin
        rd_ok  = 1'b1;
        rd_mux = 32'h0000_0000;
        case (araddr)
            ADDR_W'(decoder_pkg::CTRL_OFF):   rd_mux = {31'h0000_0000, run_r};
            ADDR_W'(decoder_pkg::WORD_OFF):   rd_mux = {18'h00000, word_r};
            ADDR_W'(decoder_pkg::FIELDS_OFF): rd_mux = {5'h00, literal_r, reg_idx_r, bit_pos_r, lit_wide_r,
                                                        wr_file_r, wr_acc_r, flush_r, group_r};
            ADDR_W'(decoder_pkg::CYCLES_OFF): rd_mux = cycles_r;
            default:                          rd_ok  = 1'b0;
        endcase
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            arready_r <= 1'b1;
            rvalid_r  <= 1'b0;
            rdata_r   <= 32'h0000_0000;
            rresp_r   <= decoder_pkg::RESP_OKAY;
        end else if (arvalid && arready_r) begin
            arready_r <= 1'b0;
            rvalid_r  <= 1'b1;
            rdata_r   <= rd_mux;
            rresp_r   <= rd_ok ? decoder_pkg::RESP_OKAY : decoder_pkg::RESP_SLVERR;
        end else if (rvalid_r && rready) begin
            arready_r <= 1'b1;
            rvalid_r  <= 1'b0;
        end
    end

    assign awready       = awready_r;
    assign wready        = wready_r;
    assign bvalid        = bvalid_r;
    assign bresp         = bresp_r;
    assign arready       = arready_r;
    assign rvalid        = rvalid_r;
    assign rdata         = rdata_r;
    assign rresp         = rresp_r;
    assign cycle_start_o = start_r;
    assign group_o       = group_r;
    assign opcode_o      = opcode_r;
    assign reg_idx_o     = reg_idx_r;
    assign wr_acc_o      = wr_acc_r;
    assign wr_file_o     = wr_file_r;
    assign bit_pos_o     = bit_pos_r;
    assign literal_o     = literal_r;
    assign lit_wide_o    = lit_wide_r;
    assign nop_cycle_o   = flush_r;

    // checks
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    logic take;
    // the release edge itself still resets the fields, so no load is claimed there
    assign take = aresetn && ph.cycle_start && !flush_pend_r;

    a_opcode_split: assert property (take |=> opcode_r == $past(instr_in[13:8]))
        else $error("opcode field not taken from top six bits");
    a_group_byte: assert property (take && instr_in[13:12] == 2'b00 |=> group_r == decoder_pkg::GRP_BYTE)
        else $error("byte group not chosen");
    a_group_bit: assert property (take && instr_in[13:12] == 2'b01 |=> group_r == decoder_pkg::GRP_BIT)
        else $error("bit group not chosen");
    a_group_lit: assert property (take && instr_in[13] |=> group_r == decoder_pkg::GRP_LIT && !flush_r)
        else $error("literal group not chosen");
    a_dest_select: assert property (take && instr_in[13:12] == 2'b00
                                    |=> wr_acc_r == !$past(instr_in[7]) && wr_file_r == $past(instr_in[7]))
        else $error("destination select wrong");
    a_reg_index: assert property (take |=> reg_idx_r == $past(instr_in[6:0]))
        else $error("register index wrong");
    a_bit_pos: assert property (take && instr_in[13:12] == 2'b01 |=> bit_pos_r == $past(instr_in[9:7]))
        else $error("bit position wrong");
    a_lit_width: assert property (take && instr_in[13:12] == 2'b11
                                  |=> !lit_wide_r && literal_r == {3'h0, $past(instr_in[7:0])})
        else $error("eight bit literal wrong");
    a_jump_flush: assert property (take && instr_in[13:12] == 2'b10 ##4 ph.cycle_start |=> flush_r)
        else $error("jump not followed by a no-op cycle");
    a_cycle_four: assert property (aresetn && ph.cycle_start |=> !ph.cycle_start [*3])
        else $error("instruction cycle shorter than four clocks");
    a_fields_hold: assert property (!ph.cycle_start |=> $stable(group_r) && $stable(literal_r))
        else $error("fields changed inside a cycle");

    c_jump:  cover property (take && instr_in[13:12] == 2'b10 ##4 ph.cycle_start ##1 flush_r);
    c_skip:  cover property (skip_r && ph.cycle_end && test_true);
    c_write: cover property (bvalid_r && bready);
    c_read:  cover property (rvalid_r && rready);
endmodule

// [phase_if.sv]
// instruction cycle phase signals between divider and decoder
`timescale 1ns/10ps
interface phase_if;
    logic       run;
    logic [1:0] phase;
    logic       cycle_start;
    logic       cycle_end;

    modport div  (input run, output phase, output cycle_start, output cycle_end);
    modport core (output run, input phase, input cycle_start, input cycle_end);
endinterface

// [quarter_div.sv]
// divides the core clock into four-period instruction cycles
`timescale 1ns/10ps
module quarter_div #(
    parameter int PERIODS = decoder_pkg::PERIODS
) (
    // clock and reset
    input  wire logic aclk,
    input  wire logic aresetn,
    // phase outputs
    phase_if.div      ph
);
    logic [1:0] phase_r;

    // free running so cycle spacing never depends on run
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            phase_r <= 2'h0;
        end else if (phase_r == 2'(PERIODS - 1)) begin
            phase_r <= 2'h0;
        end else begin
            phase_r <= phase_r + 2'h1;
        end
    end

    assign ph.phase       = phase_r;
    assign ph.cycle_start = ph.run && (phase_r == 2'h0);
    assign ph.cycle_end   = ph.run && (phase_r == 2'(PERIODS - 1));
endmodule

// [testbench.sv]
// self-checking bench for the instruction field decoder
`timescale 1ns/10ps
module testbench;
    localparam logic [13:0] PROG [16] = '{14'h0783, 14'h0703, 14'h0b7f, 14'h1a85, 14'h2fff, 14'h3f55,
        14'h0009, 14'h0064, 14'h0060, 14'h3755, 14'h0183, 14'h0008, 14'h1e05, 14'h0f00, 14'h2123,
        14'h0383};
    localparam logic [15:0] TTB = 16'ha00e;
    localparam logic [15:0] PWB = 16'h0400;
    logic        aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
    logic        awready, wready, bvalid, arready, rvalid;
    logic [7:0]  awaddr, araddr;
    logic [31:0] wdata, rdata, rd;
    logic [3:0]  wstrb;
    logic [1:0]  bresp, rresp, rs, group_o;
    logic [13:0] instr_in;
    logic        test_true, pc_written, cycle_start_o, wr_acc_o, wr_file_o, lit_wide_o, nop_cycle_o;
    logic [5:0]  opcode_o;
    logic [6:0]  reg_idx_o;
    logic [2:0]  bit_pos_o;
    logic [10:0] literal_o;
    logic [32:0] ev, cur;
    logic        gap_ok, exp_nop;
    int          fails, n_checks, cyc, gap, pulses, cnt0;

    assign cur = {group_o, opcode_o, reg_idx_o, wr_acc_o, wr_file_o, bit_pos_o, literal_o, lit_wide_o, nop_cycle_o};

    initial begin
        aclk = 1'b0;
        forever #25 aclk = ~aclk;
    end

    instr_decoder i_instr_decoder (.aclk, .aresetn, .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid, .wready,
        .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid, .rready, .instr_in,
        .test_true, .pc_written, .cycle_start_o, .group_o, .opcode_o, .reg_idx_o, .wr_acc_o, .wr_file_o,
        .bit_pos_o, .literal_o, .lit_wide_o, .nop_cycle_o);
    fetch_model i_fetch_model (.aclk, .aresetn, .cycle_start_o, .nop_cycle_o, .instr_in, .test_true, .pc_written);

    task automatic report_and_stop;
        if (fails == 0 && n_checks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    task automatic chk32(input string nm, input logic [31:0] e, input logic [31:0] g);
        n_checks++;
        if (g !== e) begin
            fails++;
            $display("unexpected %s: expected %h, seen %h", nm, e, g);
        end
    endtask

    task automatic chk2(input string nm, input logic [1:0] e, input logic [1:0] g);
        n_checks++;
        if (g !== e) begin
            fails++;
            $display("unexpected %s: expected %b, seen %b", nm, e, g);
        end
    endtask

    task automatic chkd(input string nm, input logic [32:0] e, input logic [32:0] g);
        n_checks++;
        if (g !== e) begin
            fails++;
            $display("unexpected %s: expected %h, seen %h", nm, e, g);
        end
    endtask

    // expected decode, packed like cur
    function automatic logic [32:0] dec_exp(input logic [13:0] w);
        logic       by;
        logic       lw;
        logic [1:0] g;
        by = (w[13:12] == 2'b00);
        lw = (w[13:12] == 2'b10);
        g  = by ? 2'b00 : ((w[13:12] == 2'b01) ? 2'b01 : 2'b10);
        dec_exp = {g, w[13:8], w[6:0], by & ~w[7], by & w[7], w[9:7], lw ? w[10:0] : {3'b000, w[7:0]}, lw, 1'b0};
    endfunction

    // skip tests are only the two byte skip opcodes and the two bit tests
    function automatic logic nop_next(input logic [13:0] w, input logic t, input logic p);
        nop_next = w[13:12] == 2'b10 || w[13:10] == 4'b1101 || w == decoder_pkg::RETURN_WORD
            || w == decoder_pkg::RETFIE_WORD || p
            || (t && ((w[13:12] == 2'b00 && w[11] && w[9:8] == 2'b11) || w[13:11] == 3'b011));
    endfunction

    function automatic logic [31:0] fields_of(input logic [32:0] v);
        fields_of = {5'b0, v[12:2], v[24:18], v[15:13], v[1], v[16], v[17], v[0], v[32:31]};
    endfunction

    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s, input logic [1:0] er);
        int   n;
        logic ah, wh, bh;
        @(posedge aclk);
        awaddr  <= a;
        awvalid <= 1'b1;
        wdata   <= d;
        wstrb   <= s;
        wvalid  <= 1'b1;
        bready  <= 1'b1;
        n = 0;
        do begin
            @(negedge aclk);
            ah = awvalid & awready;
            wh = wvalid & wready;
            bh = bvalid & bready;
            rs = bresp;
            @(posedge aclk);
            if (ah)
                awvalid <= 1'b0;
            if (wh)
                wvalid <= 1'b0;
            n++;
        end while (!bh && n < 50);
        bready <= 1'b0;
        gap_ok = 1'b0;
        chk2("bresp", er, bh ? rs : 2'bxx);
    endtask

    task automatic rdc(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
        int   n;
        logic ah, rh;
        @(posedge aclk);
        araddr  <= a;
        arvalid <= 1'b1;
        rready  <= 1'b1;
        n = 0;
        do begin
            @(negedge aclk);
            ah = arvalid & arready;
            rh = rvalid & rready;
            rd = rdata;
            rs = rresp;
            @(posedge aclk);
            if (ah)
                arvalid <= 1'b0;
            n++;
        end while (!rh && n < 50);
        rready <= 1'b0;
        chk2("rresp", er, rh ? rs : 2'bxx);
        chk32("rdata", ed, rd);
    endtask

    // decode monitor: a fresh field set at each start pulse, held otherwise
    always @(negedge aclk) begin
        if (!aresetn) begin
            ev      = '0;
            exp_nop = 1'b0;
            gap_ok  = 1'b0;
        end else begin
            gap++;
            if (cycle_start_o === 1'b1) begin
                if (gap_ok)
                    chk32("cadence", 32'(decoder_pkg::PERIODS), 32'(gap));
                gap    = 0;
                gap_ok = 1'b1;
                pulses++;
                ev = exp_nop ? 33'h1 : dec_exp(instr_in);
                chkd("fields", ev, cur);
                exp_nop = !exp_nop && nop_next(instr_in, i_fetch_model.tt[i_fetch_model.idx],
                    i_fetch_model.pw[i_fetch_model.idx]);
            end else begin
                chkd("held", ev, cur);
            end
        end
    end

    always @(posedge aclk) begin
        cyc++;
        if (cyc >= 5000) begin
            fails++;
            report_and_stop;
        end
    end

    initial begin
        {aresetn, awvalid, wvalid, bready, arvalid, rready} = '0;
        {awaddr, araddr, wdata, wstrb} = '0;
        {fails, n_checks, cyc, gap, pulses, cnt0} = '0;
        #1;
        for (int i = 0; i < 16; i++) begin
            i_fetch_model.prog[i] = PROG[i];
            i_fetch_model.tt[i]   = TTB[i];
            i_fetch_model.pw[i]   = PWB[i];
        end
        repeat (4) @(posedge aclk);
        aresetn <= 1'b1;
        repeat (100) @(posedge aclk);
        rdc(decoder_pkg::CTRL_OFF, 32'h1, decoder_pkg::RESP_OKAY);
        wr(decoder_pkg::CTRL_OFF, 32'h0, 4'he, decoder_pkg::RESP_OKAY);
        rdc(decoder_pkg::CTRL_OFF, 32'h1, decoder_pkg::RESP_OKAY);
        wr(decoder_pkg::WORD_OFF, 32'h0, 4'hf, decoder_pkg::RESP_SLVERR);
        wr(8'h14, 32'h0, 4'hf, decoder_pkg::RESP_SLVERR);
        rdc(8'h10, 32'h0, decoder_pkg::RESP_SLVERR);
        // stop and clear together, then confirm nothing loads
        wr(decoder_pkg::CTRL_OFF, 32'h2, 4'hf, decoder_pkg::RESP_OKAY);
        repeat (8) @(posedge aclk);
        cnt0 = pulses;
        rdc(decoder_pkg::CYCLES_OFF, 32'h0, decoder_pkg::RESP_OKAY);
        repeat (12) @(posedge aclk);
        chk32("stalled", 32'(cnt0), 32'(pulses));
        rdc(decoder_pkg::FIELDS_OFF, fields_of(ev), decoder_pkg::RESP_OKAY);
        wr(decoder_pkg::CTRL_OFF, 32'h1, 4'hf, decoder_pkg::RESP_OKAY);
        repeat (40) @(posedge aclk);
        wr(decoder_pkg::CTRL_OFF, 32'h0, 4'hf, decoder_pkg::RESP_OKAY);
        repeat (8) @(posedge aclk);
        rdc(decoder_pkg::CYCLES_OFF, 32'(pulses - cnt0), decoder_pkg::RESP_OKAY);
        rdc(decoder_pkg::FIELDS_OFF, fields_of(ev), decoder_pkg::RESP_OKAY);
        report_and_stop;
    end
endmodule
